// ===== logic/acc_conv_ctrl.sv
// converter control sequencer with register port and trigger handling
`timescale 1ns/100ps
`default_nettype none
module acc_conv_ctrl
    import acc_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire acc_bus_req_t bus,
    output logic [DATA_W-1:0] rdata,
    input wire logic timer_compare_match,
    input wire logic second_timer_underflow,
    input wire logic cmp_high_pin,
    input wire logic over_ref_pin,
    output logic [3:0] analog_channel,
    output logic sample_hold_on,
    output logic sampling,
    output logic [9:0] trial_code,
    output logic ref_connect,
    output logic conv_irq_req
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARMED = 3'b010,
        ST_CONV = 3'b100
    } acc_state_t;

    acc_state_t state, next_state;
    logic [2:0] input_select;
    logic repeat_mode, trigger_source_sel, conv_go;
    logic width_sel, hold_enable, input_group_sel;
    logic [9:0] result;
    logic wr_ctrl0, wr_ctrl1, wr_ctrl2;
    logic sw_go, timer_event, start, abort, finish, oneshot_end;
    logic eng_busy, eng_done;
    logic [9:0] eng_result;
    acc_cfg_t cfg;

    assign wr_ctrl0 = bus.wr && bus.addr == OFS_CTRL0;
    assign wr_ctrl1 = bus.wr && bus.addr == OFS_CTRL1;
    assign wr_ctrl2 = bus.wr && bus.addr == OFS_CTRL2;
    assign timer_event = timer_compare_match || second_timer_underflow;
    assign cfg = '{wide: width_sel, hold: hold_enable};

    // start and stop conditions of the sequencer
    assign sw_go = wr_ctrl0 && bus.wdata[GO_BIT]
                   && !bus.wdata[TRIG_BIT];
    assign abort = state == ST_CONV && !conv_go;
    assign finish = state == ST_CONV && conv_go && eng_done;
    assign oneshot_end = finish && !repeat_mode;
    assign start = (state == ST_IDLE && sw_go)
                 || (state == ST_ARMED && conv_go && timer_event)
                 || (finish && repeat_mode);

    // next state selection
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (wr_ctrl0 && bus.wdata[GO_BIT])
                    next_state = bus.wdata[TRIG_BIT] ? ST_ARMED : ST_CONV;
            ST_ARMED:
                if (!conv_go)
                    next_state = ST_IDLE;
                else if (timer_event)
                    next_state = ST_CONV;
            ST_CONV:
                if (abort)
                    next_state = ST_IDLE;
                else if (oneshot_end)
                    next_state = trigger_source_sel ? ST_ARMED : ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    // sequencer state
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // conv_ctrl_0 fields; a software write wins over the hardware clear
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            input_select <= CTRL_RESET[SEL_MSB:SEL_LSB];
            repeat_mode <= CTRL_RESET[REPEAT_BIT];
            trigger_source_sel <= CTRL_RESET[TRIG_BIT];
            conv_go <= CTRL_RESET[GO_BIT];
        end
        else if (wr_ctrl0)
        begin
            input_select <= bus.wdata[SEL_MSB:SEL_LSB];
            repeat_mode <= bus.wdata[REPEAT_BIT];
            trigger_source_sel <= bus.wdata[TRIG_BIT];
            conv_go <= bus.wdata[GO_BIT];
        end
        else if (oneshot_end && !trigger_source_sel)
            conv_go <= 1'b0;
    end

    // conv_ctrl_1 and conv_ctrl_2 fields
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            width_sel <= CTRL_RESET[WIDTH_BIT];
            ref_connect <= CTRL_RESET[REF_BIT];
            hold_enable <= CTRL_RESET[HOLD_BIT];
            input_group_sel <= CTRL_RESET[GROUP_BIT];
        end
        else
        begin
            if (wr_ctrl1)
            begin
                width_sel <= bus.wdata[WIDTH_BIT];
                ref_connect <= bus.wdata[REF_BIT];
            end
            if (wr_ctrl2)
            begin
                hold_enable <= bus.wdata[HOLD_BIT];
                input_group_sel <= bus.wdata[GROUP_BIT];
            end
        end
    end

    // analog mux select, hold mode and completion request to the macro side
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            analog_channel <= 4'h0;
            sample_hold_on <= 1'b0;
            conv_irq_req <= 1'b0;
        end
        else
        begin
            analog_channel <= acc_channel(input_group_sel, input_select);
            sample_hold_on <= hold_enable;
            conv_irq_req <= oneshot_end;
        end
    end

    // result only on a finished, non-aborted conversion
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            result <= 10'h000;
        else if (finish)
            result <= eng_result;
    end

    // register read data, valid the cycle after the read strobe
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            rdata <= READ_NONE;
        else if (!bus.rd)
            rdata <= READ_NONE;
        else
        begin
            rdata <= READ_NONE;
            case (bus.addr)
                OFS_CTRL0:
                begin
                    rdata[SEL_MSB:SEL_LSB] <= input_select;
                    rdata[REPEAT_BIT] <= repeat_mode;
                    rdata[TRIG_BIT] <= trigger_source_sel;
                    rdata[GO_BIT] <= conv_go;
                end
                OFS_CTRL1:
                begin
                    rdata[WIDTH_BIT] <= width_sel;
                    rdata[REF_BIT] <= ref_connect;
                end
                OFS_CTRL2:
                begin
                    rdata[HOLD_BIT] <= hold_enable;
                    rdata[GROUP_BIT] <= input_group_sel;
                end
                OFS_RESULT:
                    rdata[9:0] <= result;
                default:
                    rdata <= READ_NONE;
            endcase
        end
    end

    // conversion timing and approximation
    acc_sar_engine u_engine (
        .clock(clock),
        .arst_n(arst_n),
        .start(start),
        .abort(abort),
        .cfg(cfg),
        .cmp_high_pin(cmp_high_pin),
        .over_ref_pin(over_ref_pin),
        .busy(eng_busy),
        .sampling(sampling),
        .trial_code(trial_code),
        .done(eng_done),
        .result(eng_result)
    );

    // helper: length of the current busy stretch
    logic [6:0] busy_len;
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            busy_len <= 7'h00;
        else if (start)
            busy_len <= 7'h00;
        else if (eng_busy)
            busy_len <= busy_len + 7'h01;
    end

    chan_map_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        ##1 analog_channel ==
            acc_channel($past(input_group_sel), $past(input_select)))
        else $error("analog channel does not follow select fields");

    one_shot_stop_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        oneshot_end |=> !eng_busy ##1 (!eng_busy || $past(start)))
        else $error("one-shot conversion restarted by itself");

    sw_start_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        state == ST_IDLE && sw_go |=> eng_busy && state == ST_CONV)
        else $error("software start did not begin conversion");

    timer_start_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        state == ST_ARMED && conv_go && timer_event && !wr_ctrl0
            |=> eng_busy)
        else $error("timer event did not start conversion");

    irq_cause_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        conv_irq_req |-> $past(eng_done) && !$past(repeat_mode))
        else $error("request without one-shot completion");

    go_clear_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        oneshot_end && !trigger_source_sel && !wr_ctrl0 |=> !conv_go)
        else $error("conv_go not cleared after software one-shot");

    stop_any_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        state == ST_CONV && !conv_go |=> !eng_busy && state == ST_IDLE)
        else $error("clearing conv_go did not stop conversion");

    conv_len_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        $rose(eng_done) |->
            busy_len == acc_conv_cycles(width_sel, hold_enable))
        else $error("conversion length differs from timing table");

    repeat_quiet_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        finish && repeat_mode |=> !conv_irq_req && eng_busy)
        else $error("repeat mode raised request or did not restart");

    result_load_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        finish |=> result == $past(eng_result))
        else $error("result register not loaded at completion");

    result_hold_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        !finish |=> $stable(result))
        else $error("result changed outside completion");

    busy_flag_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        eng_busy && state == ST_CONV && !wr_ctrl0 |=> conv_go || !eng_busy)
        else $error("conv_go dropped during conversion");

    // register port and pin checks
    rdata_idle_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        !bus.rd |=> rdata == READ_NONE)
        else $error("read data not zero outside a read");

    result_read_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        bus.rd && bus.addr == OFS_RESULT |=> rdata[9:0] == $past(result))
        else $error("result read returned wrong value");

    go_read_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        bus.rd && bus.addr == OFS_CTRL0 |=> rdata[GO_BIT] == $past(conv_go))
        else $error("conv_go read back wrong");

    hold_mirror_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        ##1 sample_hold_on == $past(hold_enable))
        else $error("hold select not passed to the macro");

    armed_wait_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        state == ST_ARMED && !timer_event |=> !eng_busy)
        else $error("armed sequencer started without a timer event");

    group_chan_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        input_group_sel |=> analog_channel[3:2] == 2'b10)
        else $error("upper group did not select inputs 8 to 11");

    hold_len_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        $rose(eng_done) && hold_enable |->
            busy_len == (width_sel ? CYC_10_HOLD : CYC_8_HOLD))
        else $error("sample-and-hold conversion length wrong");

    irq_pulse_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        conv_irq_req |=> !conv_irq_req)
        else $error("completion request longer than one cycle");

    abort_keep_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        abort |=> $stable(result))
        else $error("stopped conversion changed the result");
endmodule
`default_nettype wire

// ===== common/acc_pkg.sv
// package with offsets, fields, timing counts and carriers of the converter
`default_nettype none
package acc_pkg;
    // register bus shape
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] OFS_CTRL0 = 4'h0;
    localparam logic [3:0] OFS_CTRL1 = 4'h4;
    localparam logic [3:0] OFS_CTRL2 = 4'h8;
    localparam logic [3:0] OFS_RESULT = 4'hc;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] READ_NONE = 16'h0000;
    // conv_ctrl_0 fields
    localparam int SEL_LSB = 0;
    localparam int SEL_MSB = 2;
    localparam int REPEAT_BIT = 3;
    localparam int TRIG_BIT = 5;
    localparam int GO_BIT = 6;
    // conv_ctrl_1 fields
    localparam int WIDTH_BIT = 3;
    localparam int REF_BIT = 5;
    // conv_ctrl_2 fields
    localparam int HOLD_BIT = 0;
    localparam int GROUP_BIT = 4;
    // conversion lengths in converter clock cycles
    localparam logic [6:0] CYC_8_PLAIN = 7'd49;
    localparam logic [6:0] CYC_10_PLAIN = 7'd59;
    localparam logic [6:0] CYC_8_HOLD = 7'd28;
    localparam logic [6:0] CYC_10_HOLD = 7'd33;
    // approximation span: three cycles per bit
    localparam logic [1:0] PHASE_LAST = 2'h2;
    localparam logic [6:0] SPAN_8 = 7'd24;
    localparam logic [6:0] SPAN_10 = 7'd30;
    localparam logic [3:0] MSB_8 = 4'h7;
    localparam logic [3:0] MSB_10 = 4'h9;
    localparam logic [9:0] ONES_8 = 10'h0ff;
    localparam logic [9:0] ONES_10 = 10'h3ff;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } acc_bus_req_t;

    typedef struct packed {
        logic wide;
        logic hold;
    } acc_cfg_t;

    // input number from group bit and select code
    function automatic logic [3:0] acc_channel(input logic group,
                                               input logic [2:0] sel);
        acc_channel = group ? {2'b10, sel[1:0]} : {1'b0, sel};
    endfunction

    // total cycles of one conversion
    function automatic logic [6:0] acc_conv_cycles(input logic wide,
                                                   input logic hold);
        if (hold)
            acc_conv_cycles = wide ? CYC_10_HOLD : CYC_8_HOLD;
        else
            acc_conv_cycles = wide ? CYC_10_PLAIN : CYC_8_PLAIN;
    endfunction
endpackage
`default_nettype wire

// ===== logic/acc_sar_engine.sv
// successive approximation timing engine for one conversion
`timescale 1ns/100ps
`default_nettype none
module acc_sar_engine
    import acc_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic start,
    input wire logic abort,
    input wire acc_cfg_t cfg,
    input wire logic cmp_high_pin,
    input wire logic over_ref_pin,
    output logic busy,
    output logic sampling,
    output logic [9:0] trial_code,
    output logic done,
    output logic [9:0] result
);
    logic cmp_s1, cmp_s2, ovr_s1, ovr_s2;
    logic [6:0] cycle, total_q, sample_q;
    logic [1:0] phase;
    logic [3:0] bit_idx, msb_q;
    logic wide_q;
    logic [9:0] code, next_code;
    logic approx;

    // two-stage synchronisers for the analog comparator pins
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cmp_s1 <= 1'b0;
            cmp_s2 <= 1'b0;
            ovr_s1 <= 1'b0;
            ovr_s2 <= 1'b0;
        end
        else
        begin
            cmp_s1 <= cmp_high_pin;
            cmp_s2 <= cmp_s1;
            ovr_s1 <= over_ref_pin;
            ovr_s2 <= ovr_s1;
        end
    end

    assign approx = busy && (cycle > sample_q);
    assign sampling = busy && (cycle <= sample_q);
    assign trial_code = code;

    // trial bit set after sampling, decided on the last phase of each bit
    always_comb
    begin
        next_code = code;
        if (busy && cycle == sample_q)
            next_code[msb_q] = 1'b1;
        else if (approx && phase == PHASE_LAST)
        begin
            next_code[bit_idx] = cmp_s2;
            if (bit_idx != 4'h0)
                next_code[bit_idx - 4'h1] = 1'b1;
        end
    end

    // cycle, phase and bit sequencing
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busy <= 1'b0;
            cycle <= 7'h00;
            total_q <= 7'h00;
            sample_q <= 7'h00;
            phase <= 2'h0;
            bit_idx <= 4'h0;
            msb_q <= 4'h0;
            wide_q <= 1'b0;
            code <= 10'h000;
        end
        else if (abort)
            busy <= 1'b0;
        else if (start)
        begin
            busy <= 1'b1;
            cycle <= 7'h01;
            total_q <= acc_conv_cycles(cfg.wide, cfg.hold);
            sample_q <= acc_conv_cycles(cfg.wide, cfg.hold)
                        - (cfg.wide ? SPAN_10 : SPAN_8);
            msb_q <= cfg.wide ? MSB_10 : MSB_8;
            bit_idx <= cfg.wide ? MSB_10 : MSB_8;
            wide_q <= cfg.wide;
            phase <= 2'h0;
            code <= 10'h000;
        end
        else if (busy)
        begin
            cycle <= cycle + 7'h01;
            code <= next_code;
            if (cycle == total_q)
                busy <= 1'b0;
            if (approx)
            begin
                phase <= (phase == PHASE_LAST) ? 2'h0 : phase + 2'h1;
                if (phase == PHASE_LAST && bit_idx != 4'h0)
                    bit_idx <= bit_idx - 4'h1;
            end
        end
    end

    // finished code with clamp when input is above reference
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            done <= 1'b0;
            result <= 10'h000;
        end
        else
        begin
            done <= busy && !abort && !start && (cycle == total_q);
            if (busy && !abort && !start && cycle == total_q)
                result <= ovr_s2 ? (wide_q ? ONES_10 : ONES_8)
                                 : next_code;
        end
    end

    clamp_ones_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        $rose(done) && $past(ovr_s2) |->
            result == (wide_q ? ONES_10 : ONES_8))
        else $error("over-reference result not all ones");

    narrow_code_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        done && !wide_q |-> result[9:8] == 2'b00)
        else $error("8-bit result has upper bits set");
endmodule
`default_nettype wire

// ===== dv/acc_analog_model.sv
// behavioural analog front end: input sampler, comparator, reference detector
`timescale 1ns/100ps
`default_nettype none
module acc_analog_model (
    input wire logic clock,
    input wire logic [3:0] analog_channel,
    input wire logic sampling,
    input wire logic sample_hold_on,
    input wire logic [9:0] trial_code,
    input wire logic wide,
    input wire logic [9:0] volts [12],
    input wire logic [11:0] over_mask,
    output logic cmp_high_pin,
    output logic over_ref_pin
);
    logic [9:0] held = 10'h0;
    logic over_now;

    // sampler tracks the selected input while sampling, holds after it
    always @(posedge clock)
        if (sampling === 1'b1 && analog_channel < 4'hc)
            held <= volts[analog_channel];

    // level sits mid-quantum, so it is above any trial code up to its own
    assign cmp_high_pin = wide ? (held >= trial_code)
                               : (held[9:2] >= trial_code[7:0]);

    // selected input above the reference
    assign over_now = (analog_channel < 4'hc) ? over_mask[analog_channel]
                                              : 1'b0;
    assign over_ref_pin = over_now;
endmodule
`default_nettype wire

// ===== dv/test_acc_conv_ctrl.sv
// self-checking bench of the conversion sequencer against a behaviour model
`timescale 1ns/100ps
`default_nettype none
module test_acc_conv_ctrl
    import acc_pkg::*;
;
    logic clock;
    logic arst_n;
    acc_bus_req_t bus;
    logic [15:0] rdata;
    logic tmatch;
    logic tunder;
    logic cmp_high;
    logic over_ref;
    logic [3:0] chan;
    logic shon;
    logic sampling;
    logic [9:0] trial;
    logic refc;
    logic irq;
    logic wide;
    logic [11:0] over_mask;
    logic [9:0] volts [12];
    logic [15:0] rd_val;
    logic [9:0] last_res;
    logic [3:0] addrs [5] = '{OFS_CTRL0, OFS_CTRL1, OFS_CTRL2, OFS_RESULT,
                              4'h2};
    int errors;
    int cmp_count;
    int irq_count;
    int base;

    acc_conv_ctrl u_dut (
        .clock(clock), .arst_n(arst_n), .bus(bus), .rdata(rdata),
        .timer_compare_match(tmatch), .second_timer_underflow(tunder),
        .cmp_high_pin(cmp_high), .over_ref_pin(over_ref),
        .analog_channel(chan), .sample_hold_on(shon), .sampling(sampling),
        .trial_code(trial), .ref_connect(refc), .conv_irq_req(irq)
    );

    acc_analog_model u_analog (
        .clock(clock), .analog_channel(chan), .sampling(sampling),
        .sample_hold_on(shon), .trial_code(trial), .wide(wide),
        .volts(volts), .over_mask(over_mask), .cmp_high_pin(cmp_high),
        .over_ref_pin(over_ref)
    );

    // 10 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // count completion requests mid-cycle, clear of the launching edge
    always @(negedge clock)
        if (irq === 1'b1)
            irq_count++;

    task automatic end_sim;
        if (errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_int(input int got, input int exp);
        cmp_count++;
        if (got != exp)
        begin
            errors++;
            $display("MISMATCH t=%0t count %0d exp %0d", $time, got, exp);
        end
    endtask

    // one-cycle bus write, strobe dropped before the next access
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        bus.wr <= 1'b0;
        @(posedge clock);
    endtask

    // one-cycle bus read, data taken in the following cycle
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0};
        @(posedge clock);
        bus.rd <= 1'b0;
        @(posedge clock);
        d = rdata;
    endtask

    // poll busy flag and stale result, then time the completion request
    task automatic wait_irq(input int n0, input int exp_n);
        int n;
        n = n0 + 4;
        rd(OFS_CTRL0, rd_val);
        chk(16'(rd_val[GO_BIT]), 16'h1);
        rd(OFS_RESULT, rd_val);
        chk(rd_val, {6'h0, last_res});
        while (irq !== 1'b1 && n < 300)
        begin
            @(posedge clock);
            n++;
        end
        chk_int(n, exp_n);
    endtask

    // software one-shot on one input, checked against the model
    task automatic convert(input int ch, input logic w, input logic h,
                           input logic ovr);
        logic [2:0] sel;
        logic grp;
        logic [9:0] v;
        int cyc;
        grp = (ch > 7);
        sel = grp ? 3'(ch - 4) : 3'(ch);
        v = 10'($urandom_range(1023));
        volts[ch] <= v;
        over_mask <= ovr ? (12'h1 << ch) : 12'h0;
        wide <= w;
        wr(OFS_CTRL1, (16'(w) << WIDTH_BIT) | (16'h1 << REF_BIT));
        repeat (10) @(posedge clock);
        wr(OFS_CTRL2, (16'(h) << HOLD_BIT) | (16'(grp) << GROUP_BIT));
        wr(OFS_CTRL0, 16'(sel) | (16'h1 << GO_BIT));
        chk(16'(shon), 16'(h));
        cyc = h ? (w ? 33 : 28) : (w ? 59 : 49);
        wait_irq(2, cyc + 3);
        chk({12'h0, chan}, 16'(ch));
        last_res = ovr ? (w ? 10'h3ff : 10'h0ff)
                       : (w ? v : {2'b0, v[9:2]});
        base = irq_count;
        rd(OFS_RESULT, rd_val);
        chk(rd_val, {6'h0, last_res});
        rd(OFS_CTRL0, rd_val);
        chk(16'(rd_val[GO_BIT]), 16'h0);
        repeat (70) @(posedge clock);
        chk_int(irq_count, base);
    endtask

    // watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge clock);
        errors++;
        end_sim();
    end

    initial
    begin
        void'($urandom(56));
        errors = 0;
        cmp_count = 0;
        irq_count = 0;
        arst_n = 1'b0;
        bus = '0;
        tmatch = 1'b0;
        tunder = 1'b0;
        wide = 1'b0;
        over_mask = 12'h0;
        last_res = 10'h0;
        foreach (volts[i])
            volts[i] = 10'h0;
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        // reset values, then an unmapped place
        foreach (addrs[i])
        begin
            rd(addrs[i], rd_val);
            chk(rd_val, CTRL_RESET);
        end
        wr(4'h2, 16'hffff);
        rd(4'h2, rd_val);
        chk(rd_val, READ_NONE);
        // every input, every timing, two over-reference cases
        for (int ch = 0; ch < 12; ch++)
            convert(ch, ch[0], ch[1], ch == 6 || ch == 11);
        // timer trigger: compare match, then underflow
        wide <= 1'b0;
        wr(OFS_CTRL1, 16'h1 << REF_BIT);
        wr(OFS_CTRL2, 16'h0);
        volts[3] <= 10'($urandom_range(1023));
        base = irq_count;
        wr(OFS_CTRL0, 16'h3 | (16'h1 << TRIG_BIT) | (16'h1 << GO_BIT));
        repeat (20) @(posedge clock);
        chk_int(irq_count, base);
        for (int i = 0; i < 2; i++)
        begin
            tmatch <= (i == 0);
            tunder <= (i == 1);
            @(posedge clock);
            tmatch <= 1'b0;
            tunder <= 1'b0;
            wait_irq(1, 52);
            last_res = {2'b0, volts[3][9:2]};
            rd(OFS_RESULT, rd_val);
            chk(rd_val, {6'h0, last_res});
            rd(OFS_CTRL0, rd_val);
            chk(16'(rd_val[GO_BIT]), 16'h1);
        end
        wr(OFS_CTRL0, 16'h3);
        // abort in mid-conversion keeps the old result, no request
        volts[3] <= ~volts[3];
        wr(OFS_CTRL0, 16'h3 | (16'h1 << GO_BIT));
        repeat (10) @(posedge clock);
        base = irq_count;
        wr(OFS_CTRL0, 16'h3);
        repeat (80) @(posedge clock);
        chk_int(irq_count, base);
        rd(OFS_RESULT, rd_val);
        chk(rd_val, {6'h0, last_res});
        // repeat mode at 8 bits follows the input, never requests
        volts[5] <= 10'h155;
        base = irq_count;
        wr(OFS_CTRL0, 16'h5 | (16'h1 << REPEAT_BIT) | (16'h1 << GO_BIT));
        repeat (120) @(posedge clock);
        volts[5] <= 10'h2aa;
        repeat (160) @(posedge clock);
        chk_int(irq_count, base);
        rd(OFS_RESULT, rd_val);
        chk(rd_val, 16'h00aa);
        rd(OFS_CTRL0, rd_val);
        chk(16'(rd_val[GO_BIT]), 16'h1);
        wr(OFS_CTRL0, 16'h5);
        wr(OFS_CTRL1, 16'h0);
        chk(16'(refc), 16'h0);
        end_sim();
    end
endmodule
`default_nettype wire
